// file: logic/core_address_generation.v
/*
  Address generation of an 8-bit core: indirect pointers, bank select,
  table pointer and latch, program counter with high-byte holding latch.
  Assumes the instruction decoder issues one operation per cycle on
  op_valid_in, and software reaches the registers over AXI4-Lite.
*/
// Our own choices: the placing of the registers and the AXI4-Lite interface to the registers.
// How it works
// - indirect ports address data via paired pointer
// - 8-bit pointers; bank register picks bank
// - access to indirect port itself is null
// - status field pairs select pointer step mode
// - pointer stepping leaves status flags alone
// - zero pointer: read zero, write nop
// - indirect moves finish in one cycle
// - two bytes form 16-bit table pointer
// - 16-bit table latch with byte access
// - 16-bit counter, high byte via holding latch
// - counter increments per fetch except jumps
// - skip runs as forced no-operation fetch
// - long call: latch to high, opcode low
// - decoder low-byte read copies high into latch; bus read of the low byte does not
// - low-byte write loads latch into high
// - read-modify-write also loads latch into high
// - paged jump loads 13 bits, updates latch
// - latch kept by long call, keep-return, vectors; plain return loads old high byte
// - bank nibbles choose peripheral and RAM bank
// - unimplemented bank: read zero, write dropped
// - table access external only in extended mode
// - word moves split into latch and access
`timescale 1ns/1ps
`include "core_addr_regs.vh"

module core_address_generation
(
  input  wire        sys_clk_in,
  input  wire        arst_n_in,
  input  wire        ce_in,
  input  wire        op_valid_in,
  input  wire [3:0]  op_code_in,
  input  wire        ind_sel_in,
  input  wire [15:0] opcode_in,
  input  wire [7:0]  bus_data_in,
  input  wire [15:0] stack_top_in,
  input  wire [15:0] vector_in,
  input  wire [15:0] prog_data_in,
  output reg  [15:0] pc_out,
  output reg  [7:0]  rd_data_out,
  output reg  [7:0]  data_addr_out,
  output reg  [3:0]  bank_out,
  output reg         access_null_out,
  output reg         zero_set_out,
  output reg         bank_unimpl_out,
  output reg  [15:0] prog_addr_out,
  output reg         prog_external_out,
  input  wire [31:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [31:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready
);

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  reg  [7:0]  ptr0_q;
  reg  [7:0]  ptr1_q;
  reg  [3:0]  step_q;
  reg         zero_q;
  reg  [7:0]  bank_q;
  reg  [15:0] tblptr_q;
  reg  [15:0] table_holding_latch_q;
  reg  [7:0]  latch_q;
  reg         ext_q;
  reg  [5:0]  aw_addr_q;
  reg  [7:0]  w_data_q;
  reg         w_lane_q;
  reg         aw_got_q;
  reg         w_got_q;

  wire [7:0]  ptr0_next;
  wire [7:0]  ptr1_next;

  // upper pair steps pointer one, lower pair pointer zero
  pointer_stepper u_step_zero
  (
    .ptr_in   (ptr0_q),
    .mode_in  (step_q[1:0]),
    .next_out (ptr0_next)
  );

  pointer_stepper u_step_one
  (
    .ptr_in   (ptr1_q),
    .mode_in  (step_q[3:2]),
    .next_out (ptr1_next)
  );

  // --------------------------------------------------------------------------
  // indirect target decode
  // --------------------------------------------------------------------------
  reg  [7:0]  ind_addr;
  reg         ind_null;
  reg         peri_win;
  reg         ram_win;
  reg         bank_bad;
  reg  [3:0]  sel_bank;

  always @*
  begin
    ind_addr = ind_sel_in ? ptr1_q : ptr0_q;
    ind_null = (ind_addr == `ADDR_PORT_ZERO) || (ind_addr == `ADDR_PORT_ONE);
    peri_win = (ind_addr >= `ADDR_PERI_LO) && (ind_addr <= `ADDR_PERI_HI);
    ram_win  = (ind_addr >= `ADDR_RAM_LO);
    sel_bank = peri_win ? bank_q[3:0] : bank_q[7:4];
    bank_bad = (peri_win && (bank_q[3:0] >= `PERI_BANKS))
             || (ram_win && (bank_q[7:4] >= `RAM_BANKS));
  end

  // --------------------------------------------------------------------------
  // bus handshakes
  // --------------------------------------------------------------------------
  wire aw_take  = s_axi_awvalid & s_axi_awready;
  wire w_take   = s_axi_wvalid & s_axi_wready;
  wire wr_fire  = aw_got_q & w_got_q & ~s_axi_bvalid;
  wire aw_got_d = (aw_got_q | aw_take) & ~wr_fire;
  wire w_got_d  = (w_got_q | w_take) & ~wr_fire;
  wire ar_take  = s_axi_arvalid & s_axi_arready;
  wire rvalid_d = (s_axi_rvalid & ~s_axi_rready) | ar_take;
  wire op_go    = ce_in & op_valid_in;
  wire sw_wr    = wr_fire & w_lane_q;

  reg         rd_hit;
  reg  [7:0]  rd_byte;

  always @*
  begin
    rd_hit  = 1'b1;
    rd_byte = 8'h00;
    case (s_axi_araddr[5:0])
      `OFS_PTR_ZERO:  rd_byte = ptr0_q;
      `OFS_PTR_ONE:   rd_byte = ptr1_q;
      `OFS_ALU_STAT:  rd_byte = {3'h0, zero_q, step_q};
      `OFS_BANK_SEL:  rd_byte = bank_q;
      `OFS_TBLPTR_LO: rd_byte = tblptr_q[7:0];
      `OFS_TBLPTR_HI: rd_byte = tblptr_q[15:8];
      `OFS_TABLE_HOLDING_LATCH_LO:  rd_byte = table_holding_latch_q[7:0];
      `OFS_TABLE_HOLDING_LATCH_HI:  rd_byte = table_holding_latch_q[15:8];
      `OFS_PC_LOW:    rd_byte = pc_out[7:0];
      `OFS_PC_LATCH:  rd_byte = latch_q;
      `OFS_PC_HIGH:   rd_byte = pc_out[15:8];
      `OFS_CONTROL:   rd_byte = {7'h00, ext_q};
      default:        rd_hit  = 1'b0;
    endcase
    if (s_axi_araddr[31:6] != 26'h0000000)
      rd_hit = 1'b0;
  end

  wire wr_hit = (aw_addr_q <= `OFS_CONTROL) && (aw_addr_q[1:0] == 2'h0);

  // --------------------------------------------------------------------------
  // bus slave
  // --------------------------------------------------------------------------
  always @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= `RESP_OKAY;
      s_axi_rdata   <= 32'h00000000;
      aw_got_q      <= 1'b0;
      w_got_q       <= 1'b0;
      aw_addr_q     <= 6'h00;
      w_data_q      <= 8'h00;
      w_lane_q      <= 1'b0;
    end
    else if (ce_in)
    begin
      aw_got_q      <= aw_got_d;
      w_got_q       <= w_got_d;
      s_axi_awready <= ~aw_got_d;
      s_axi_wready  <= ~w_got_d;
      s_axi_arready <= ~rvalid_d;
      s_axi_rvalid  <= rvalid_d;
      if (aw_take)
        aw_addr_q <= (s_axi_awaddr[31:6] == 26'h0000000) ? s_axi_awaddr[5:0] : 6'h3F;
      if (w_take)
      begin
        w_data_q <= s_axi_wdata[7:0];
        w_lane_q <= s_axi_wstrb[0];
      end
      if (wr_fire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (ar_take)
      begin
        s_axi_rdata <= {24'h000000, rd_byte};
        s_axi_rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
    end
  end

  // --------------------------------------------------------------------------
  // pointers, status, bank, table path
  // --------------------------------------------------------------------------
  wire ind_op = op_go && ((op_code_in == `OP_IND_READ) || (op_code_in == `OP_IND_WRITE));

  always @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      ptr0_q            <= `RST_BYTE;
      ptr1_q            <= `RST_BYTE;
      step_q            <= `RST_STEP;
      zero_q            <= 1'b0;
      bank_q            <= `RST_BYTE;
      tblptr_q          <= `RST_WORD;
      table_holding_latch_q           <= `RST_WORD;
      ext_q             <= 1'b0;
      data_addr_out     <= `RST_BYTE;
      bank_out          <= 4'h0;
      access_null_out   <= 1'b0;
      zero_set_out      <= 1'b0;
      bank_unimpl_out   <= 1'b0;
      prog_addr_out     <= `RST_WORD;
      prog_external_out <= 1'b0;
    end
    else if (ce_in)
    begin
      zero_set_out    <= 1'b0;
      access_null_out <= 1'b0;
      bank_unimpl_out <= 1'b0;
      // software writes first, hardware events below take precedence
      if (sw_wr)
      begin
        case (aw_addr_q)
          `OFS_PTR_ZERO:  ptr0_q <= w_data_q;
          `OFS_PTR_ONE:   ptr1_q <= w_data_q;
          `OFS_ALU_STAT:
          begin
            step_q <= w_data_q[3:0];
            zero_q <= w_data_q[`STAT_ZERO_BIT];
          end
          `OFS_BANK_SEL:  bank_q <= w_data_q;
          `OFS_TBLPTR_LO: tblptr_q[7:0] <= w_data_q;
          `OFS_TBLPTR_HI: tblptr_q[15:8] <= w_data_q;
          `OFS_TABLE_HOLDING_LATCH_LO:  table_holding_latch_q[7:0] <= w_data_q;
          `OFS_TABLE_HOLDING_LATCH_HI:  table_holding_latch_q[15:8] <= w_data_q;
          `OFS_CONTROL:   ext_q <= w_data_q[`CTRL_EXT_BIT];
          default:        ext_q <= ext_q;
        endcase
      end
      if (ind_op)
      begin
        // single-cycle resolve of the indirect target
        data_addr_out   <= ind_addr;
        bank_out        <= sel_bank;
        access_null_out <= ind_null;
        bank_unimpl_out <= bank_bad & ~ind_null;
        // null read returns zero and sets zero; null write leaves flags
        if (ind_null && (op_code_in == `OP_IND_READ))
        begin
          zero_q       <= 1'b1;
          zero_set_out <= 1'b1;
        end
        // post-access step, flags untouched even on wrap to zero
        if (ind_sel_in)
          ptr1_q <= ptr1_next;
        else
          ptr0_q <= ptr0_next;
      end
      if (op_go)
      begin
        case (op_code_in)
          `OP_TBL_ACCESS:
          begin
            prog_addr_out     <= tblptr_q;
            prog_external_out <= ext_q;
            if (opcode_in[0])
              tblptr_q <= tblptr_q + 16'h0001;
          end
          `OP_LATCH_WRITE:
            if (opcode_in[8])
              table_holding_latch_q[15:8] <= bus_data_in;
            else
              table_holding_latch_q[7:0] <= bus_data_in;
          `OP_TBL_FILL:   table_holding_latch_q <= prog_data_in;
          default:        table_holding_latch_q <= table_holding_latch_q;
        endcase
      end
    end
  end

  // --------------------------------------------------------------------------
  // program counter and holding latch
  // --------------------------------------------------------------------------
  wire sw_pcl   = sw_wr && (aw_addr_q == `OFS_PC_LOW);
  wire sw_latch = sw_wr && (aw_addr_q == `OFS_PC_LATCH);

  always @(posedge sys_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      pc_out      <= `RST_WORD;
      latch_q     <= `RST_BYTE;
      rd_data_out <= `RST_BYTE;
    end
    else if (ce_in)
    begin
      if (sw_latch)
        latch_q <= w_data_q;
      if (sw_pcl)
        pc_out <= {latch_q, w_data_q};
      if (op_go)
      begin
        case (op_code_in)
          // skipped instructions arrive here as a plain fetch
          `OP_FETCH:     pc_out <= pc_out + 16'h0001;
          `OP_PCL_READ:
          begin
            rd_data_out <= pc_out[7:0];
            latch_q     <= pc_out[15:8];
          end
          // plain write and read-modify-write both land here
          `OP_PCL_WRITE: pc_out <= {latch_q, bus_data_in};
          `OP_LONG_CALL: pc_out <= {latch_q, opcode_in[7:0]};
          `OP_JUMP:
          begin
            pc_out[12:0] <= opcode_in[12:0];
            latch_q      <= {pc_out[15:13], opcode_in[12:8]};
          end
          `OP_RETURN:
          begin
            latch_q <= pc_out[15:8];
            pc_out  <= stack_top_in;
          end
          `OP_RET_KEEP:  pc_out <= stack_top_in;
          `OP_VECTOR:    pc_out <= vector_in;
          `OP_LATCH_READ: rd_data_out <= opcode_in[8] ? table_holding_latch_q[15:8] : table_holding_latch_q[7:0];
          default:       pc_out <= pc_out;
        endcase
      end
    end
  end

endmodule // core_address_generation

// file: shared/core_addr_regs.vh
/*
  Constants for the core address-generation block: bus register offsets,
  field positions, reset values and decoder operation codes.
  Assumes inclusion by bare name from the design files.
*/
`ifndef CORE_ADDR_REGS_VH
`define CORE_ADDR_REGS_VH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define OFS_PTR_ZERO   6'h00
`define OFS_PTR_ONE    6'h04
`define OFS_ALU_STAT   6'h08
`define OFS_BANK_SEL   6'h0C
`define OFS_TBLPTR_LO  6'h10
`define OFS_TBLPTR_HI  6'h14
`define OFS_TABLE_HOLDING_LATCH_LO   6'h18
`define OFS_TABLE_HOLDING_LATCH_HI   6'h1C
`define OFS_PC_LOW     6'h20
`define OFS_PC_LATCH   6'h24
`define OFS_PC_HIGH    6'h28
`define OFS_CONTROL    6'h2C

// ----------------------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------------------
`define STAT_ZERO_BIT  4
`define CTRL_EXT_BIT   0
`define RST_BYTE       8'h00
`define RST_WORD       16'h0000
`define RST_STEP       4'hF
`define STEP_DEC       2'h0
`define STEP_INC       2'h1
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2

// ----------------------------------------------------------------------------
// data map
// ----------------------------------------------------------------------------
`define ADDR_PORT_ZERO 8'h00
`define ADDR_PORT_ONE  8'h08
`define ADDR_PERI_LO   8'h10
`define ADDR_PERI_HI   8'h17
`define ADDR_RAM_LO    8'h20
`define PERI_BANKS     4'h4
`define RAM_BANKS      4'h2

// ----------------------------------------------------------------------------
// decoder operations
// ----------------------------------------------------------------------------
`define OP_NOP         4'h0
`define OP_FETCH       4'h1
`define OP_IND_READ    4'h2
`define OP_IND_WRITE   4'h3
`define OP_PCL_READ    4'h4
`define OP_PCL_WRITE   4'h5
`define OP_LONG_CALL   4'h6
`define OP_JUMP        4'h7
`define OP_RETURN      4'h8
`define OP_RET_KEEP    4'h9
`define OP_VECTOR      4'hA
`define OP_TBL_ACCESS  4'hB
`define OP_LATCH_WRITE 4'hC
`define OP_LATCH_READ  4'hD
`define OP_TBL_FILL    4'hE

`endif

// file: logic/pointer_stepper.v
/*
  Post-access step of one indirect pointer: decrement, increment or hold.
  Assumes the caller applies the result only after an indirect access.
*/
`timescale 1ns/1ps
`include "core_addr_regs.vh"

module pointer_stepper
(
  input  wire [7:0] ptr_in,
  input  wire [1:0] mode_in,
  output reg  [7:0] next_out
);

  always @*
  begin
    case (mode_in)
      `STEP_DEC: next_out = ptr_in - 8'h01;
      `STEP_INC: next_out = ptr_in + 8'h01;
      default:   next_out = ptr_in;
    endcase
  end

endmodule // pointer_stepper

// file: dv/core_addr_props.sv
/*
  Checker for the core address generation block.
  Assumes it is bound to the top module and sees its ports only.
*/
`timescale 1ns/1ps
`include "core_addr_regs.vh"

module core_addr_props
(
  input wire logic        sys_clk_in,
  input wire logic        arst_n_in,
  input wire logic        ce_in,
  input wire logic        op_valid_in,
  input wire logic [3:0]  op_code_in,
  input wire logic [15:0] opcode_in,
  input wire logic [7:0]  bus_data_in,
  input wire logic [15:0] stack_top_in,
  input wire logic [15:0] vector_in,
  input wire logic [15:0] pc_out,
  input wire logic [7:0]  rd_data_out,
  input wire logic        access_null_out,
  input wire logic        zero_set_out,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready
);
  wire go = ce_in & op_valid_in;

  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!arst_n_in);

  fetch_step_a: assert property (go && op_code_in == `OP_FETCH |=> pc_out == $past(pc_out) + 16'h0001)
    else $error("pc did not step after fetch");
  jump_target_a: assert property (go && op_code_in == `OP_JUMP |=>
    pc_out == {$past(pc_out[15:13]), $past(opcode_in[12:0])})
    else $error("paged jump target wrong");
  long_call_a: assert property (go && op_code_in == `OP_LONG_CALL |=> pc_out[7:0] == $past(opcode_in[7:0]))
    else $error("long call low byte wrong");
  return_pop_a: assert property (go && op_code_in == `OP_RETURN |=> pc_out == $past(stack_top_in))
    else $error("return did not load stack entry");
  vector_load_a: assert property (go && op_code_in == `OP_VECTOR |=> pc_out == $past(vector_in))
    else $error("vector not forced onto pc");
  pcl_write_a: assert property (go && op_code_in == `OP_PCL_WRITE |=> pc_out[7:0] == $past(bus_data_in))
    else $error("pc low byte not loaded from bus");
  pcl_read_a: assert property (go && op_code_in == `OP_PCL_READ |=> rd_data_out == $past(pc_out[7:0]))
    else $error("pc low byte read wrong");
  null_read_a: assert property (zero_set_out |-> access_null_out && $past(op_code_in) == `OP_IND_READ)
    else $error("zero flag set outside a null read");
  null_write_a: assert property (go && op_code_in == `OP_IND_WRITE |=> !zero_set_out)
    else $error("indirect write touched zero flag");

  cover property (go && op_code_in == `OP_JUMP);
  cover property (zero_set_out);
  cover property (s_axi_bvalid && s_axi_bready);
endmodule // core_addr_props

bind core_address_generation core_addr_props core_addr_props_inst (.*);

// file: dv/decoder_model.sv
/*
  Decoder-side model: stack top, interrupt vector and program word.
  Assumes the bench chooses the values through parameters.
*/
`timescale 1ns/1ps

module decoder_model
#(
  parameter logic [15:0] STACK  = 16'h0000,
  parameter logic [15:0] VECTOR = 16'h0000,
  parameter logic [15:0] PROG   = 16'h0000
)
(
  output logic [15:0] stack_top_out,
  output logic [15:0] vector_out,
  output logic [15:0] prog_data_out
);
  assign stack_top_out = STACK;
  assign vector_out    = VECTOR;
  assign prog_data_out = PROG;
endmodule // decoder_model

// file: dv/tb_core_address_generation.sv
/*
  Self-checking bench for the core address generation block.
  Assumes the checker and the decoder model are compiled first.
*/
`timescale 1ns/1ps
`include "core_addr_regs.vh"

module tb_core_address_generation;
  localparam logic [15:0] STK = 16'h1234;
  localparam logic [15:0] VEC = 16'h0010;
  localparam logic [15:0] PRG = 16'hBEEF;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        v = 1'b0;
  logic        sel = 1'b0;
  logic        ce = 1'b1;
  logic [3:0]  code = 4'h0;
  logic [15:0] opc = 16'h0000;
  logic [7:0]  bus = 8'h00;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  wire  [15:0] sk, vc, pg, pc, padr;
  wire  [31:0] rdata;
  wire  [7:0]  rdd, dadr;
  wire  [3:0]  bank;
  wire  [1:0]  bresp, rresp;
  wire         nul, zs, unim, pext, awready, wready, bvalid, arready, rvalid;
  int          errors = 0;
  int          comparisons = 0;
  int          cyc = 0;
  logic [31:0] rv;
  logic [1:0]  rsp;

  always #20 clk = ~clk;

  decoder_model #(.STACK(STK), .VECTOR(VEC), .PROG(PRG)) decoder_model_inst
    (.stack_top_out(sk), .vector_out(vc), .prog_data_out(pg));

  core_address_generation core_address_generation_inst (
    .sys_clk_in(clk), .arst_n_in(rst_n), .ce_in(ce), .op_valid_in(v), .op_code_in(code),
    .ind_sel_in(sel), .opcode_in(opc), .bus_data_in(bus), .stack_top_in(sk),
    .vector_in(vc), .prog_data_in(pg), .pc_out(pc), .rd_data_out(rdd),
    .data_addr_out(dadr), .bank_out(bank), .access_null_out(nul), .zero_set_out(zs),
    .bank_unimpl_out(unim), .prog_addr_out(padr), .prog_external_out(pext),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    comparisons++;
    if (s !== e)
    begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  task end_of_test;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    awaddr <= {24'h0, a};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while ((awvalid && !awready) || (wvalid && !wready));
    bready <= 1'b1;
    do @(posedge clk); while (!bvalid);
    rsp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    araddr <= {24'h0, a};
    arvalid <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge clk); while (!rvalid);
    rv = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask

  // one decoder op, results checked just after the taking edge
  task automatic op(input logic [3:0] c, input logic [15:0] o, input logic [7:0] b, input logic s);
    @(posedge clk);
    v <= 1'b1;
    code <= c;
    opc <= o;
    bus <= b;
    sel <= s;
    @(posedge clk);
    v <= 1'b0;
    #1;
  endtask

  task t_pc;
    wr(8'h24, 8'h40);
    op(`OP_PCL_WRITE, 16'h0000, 8'h00, 1'b0);
    chk(pc, 16'h4000);
    op(`OP_JUMP, 16'h1ABC, 8'h00, 1'b0);
    chk(pc, 16'h5ABC);
    rd(8'h24);
    chk(rv[15:0], 16'h005A);
    wr(8'h24, 8'h11);
    op(`OP_PCL_READ, 16'h0000, 8'h00, 1'b0);
    chk({8'h00, rdd}, 16'h00BC);
    rd(8'h24);
    chk(rv[15:0], 16'h005A);
    op(`OP_LONG_CALL, 16'h0033, 8'h00, 1'b0);
    chk(pc, 16'h5A33);
    op(`OP_FETCH, 16'h0000, 8'h00, 1'b0);
    chk(pc, 16'h5A34);
    wr(8'h24, 8'h11);
    op(`OP_RETURN, 16'h0000, 8'h00, 1'b0);
    chk(pc, STK);
    rd(8'h24);
    chk(rv[15:0], 16'h005A);
    wr(8'h24, 8'h66);
    op(`OP_VECTOR, 16'h0000, 8'h00, 1'b0);
    chk(pc, VEC);
    op(`OP_RET_KEEP, 16'h0000, 8'h00, 1'b0);
    chk(pc, STK);
    rd(8'h24);
    chk(rv[15:0], 16'h0066);
    wr(8'h24, 8'h03);
    op(`OP_PCL_WRITE, 16'h0000, 8'h20, 1'b0);
    chk(pc, 16'h0320);
    $display("program counter test done");
  endtask

  task t_ind;
    wr(8'h00, 8'h30);
    wr(8'h04, 8'h01);
    wr(8'h08, 8'h01);
    op(`OP_IND_READ, 16'h0000, 8'h00, 1'b0);
    chk({8'h00, dadr}, 16'h0030);
    rd(8'h00);
    chk(rv[15:0], 16'h0031);
    op(`OP_IND_WRITE, 16'h0000, 8'h00, 1'b1);
    chk({8'h00, dadr}, 16'h0001);
    rd(8'h04);
    chk(rv[15:0], 16'h0000);
    rd(8'h08);
    chk(rv[15:0], 16'h0001);
    op(`OP_IND_READ, 16'h0000, 8'h00, 1'b1);
    chk({14'h0, nul, zs}, 16'h0003);
    rd(8'h08);
    chk(rv[15:0], 16'h0011);
    wr(8'h00, 8'h08);
    op(`OP_IND_WRITE, 16'h0000, 8'h00, 1'b0);
    chk({14'h0, nul, zs}, 16'h0002);
    $display("indirect test done");
  endtask

  task automatic bank_case(input logic [7:0] bank_select_register, input logic [7:0] a, input logic [3:0] eb, input logic eu);
    wr(8'h0C, bank_select_register);
    wr(8'h00, a);
    op(`OP_IND_READ, 16'h0000, 8'h00, 1'b0);
    chk({11'h0, unim, bank}, {11'h0, eu, eb});
  endtask

  task t_bank;
    bank_case(8'h15, 8'h12, 4'h5, 1'b1);
    bank_case(8'h12, 8'h12, 4'h2, 1'b0);
    bank_case(8'h23, 8'h25, 4'h2, 1'b1);
    $display("bank test done");
  endtask

  task t_tbl;
    wr(8'h10, 8'h34);
    wr(8'h14, 8'h12);
    wr(8'h2C, 8'h00);
    op(`OP_TBL_ACCESS, 16'h0000, 8'h00, 1'b0);
    chk(padr, 16'h1234);
    chk({15'h0, pext}, 16'h0000);
    wr(8'h2C, 8'h01);
    op(`OP_TBL_ACCESS, 16'h0001, 8'h00, 1'b0);
    chk({15'h0, pext}, 16'h0001);
    rd(8'h10);
    chk(rv[15:0], 16'h0035);
    op(`OP_TBL_FILL, 16'h0000, 8'h00, 1'b0);
    op(`OP_LATCH_READ, 16'h0100, 8'h00, 1'b0);
    chk({8'h00, rdd}, {8'h00, PRG[15:8]});
    rd(8'h18);
    chk(rv[15:0], {8'h00, PRG[7:0]});
    op(`OP_LATCH_WRITE, 16'h0000, 8'h77, 1'b0);
    rd(8'h18);
    chk(rv[15:0], 16'h0077);
    op(`OP_LATCH_WRITE, 16'h0100, 8'h5C, 1'b0);
    rd(8'h1C);
    chk(rv[15:0], 16'h005C);
    rd(8'h30);
    chk({14'h0, rsp}, {14'h0, `RESP_SLVERR});
    wr(8'h30, 8'h55);
    chk({14'h0, rsp}, {14'h0, `RESP_SLVERR});
    $display("table and map test done");
  endtask

  // enable low freezes the counter; mid-run reset clears it and the latch to zero
  task t_ce;
    @(posedge clk);
    ce <= 1'b0;
    op(`OP_FETCH, 16'h0000, 8'h00, 1'b0);
    chk(pc, 16'h0320);
    @(posedge clk);
    ce <= 1'b1;
    op(`OP_FETCH, 16'h0000, 8'h00, 1'b0);
    chk(pc, 16'h0321);
    @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk(pc, 16'h0000);
    rd(8'h24);
    chk(rv[15:0], 16'h0000);
    $display("enable and reset test done");
  endtask

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 4000)
    begin
      errors++;
      end_of_test;
    end
  end

  initial
  begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    t_pc;
    t_ind;
    t_bank;
    t_tbl;
    t_ce;
    end_of_test;
  end
endmodule // tb_core_address_generation
